// file: dv/serial_peer.sv
// Remote serial device model facing the transmit and receive pins
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
   // Clock
   input  wire logic       pclk,
   // Serial lines
   input  wire logic       txd,
   output var  logic       rxd,
   // Last captured frame and frame count
   output var  logic [8:0] got,
   output var  logic [3:0] frames
);
   initial begin
      rxd = 1'b1;
      got = 9'h000;
      frames = 4'h0;
   end
   // Frame out LSB first; a zero stop bit ends early to avoid a false start
   task automatic send(input logic [7:0] d, input logic stop_bit);
      rxd <= 1'b0;
      repeat (16) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
         rxd <= d[i];
         repeat (16) @(posedge pclk);
      end
      rxd <= stop_bit;
      repeat (stop_bit ? 16 : 12) @(posedge pclk);
      rxd <= 1'b1;
      @(posedge pclk);
   endtask
   // Samples the nine bits after the start bit at mid bit
   always begin
      @(negedge txd);
      repeat (8) @(posedge pclk);
      for (int i = 0; i < 9; i++) begin
         repeat (16) @(posedge pclk);
         got[i] = txd;
      end
      frames = frames + 4'h1;
   end
endmodule
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the serial channel register file
`timescale 1ns/1ps
`default_nettype none
module tb;
   import usart_pkg::*;
   typedef struct packed {logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] e; logic err;} row_t;
   logic        pclk, presetn, psel, penable, pwrite, gie, ack, er;
   logic        pready, pslverr, rxc_req, txc_req, udre_req, rxd, rxd_owned, txd, txd_oe;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [8:0]  got;
   logic [3:0]  frames;
   int          mismatches, samples_checked;
   row_t        rows [16] = '{
      '{1'b0, OFF_STAT_A, 8'h00, 8'h20, 1'b0},
      '{1'b0, OFF_CTRL_B, 8'h00, 8'h00, 1'b0},
      '{1'b0, OFF_CTRL_C, 8'h00, 8'h06, 1'b0},
      '{1'b0, 8'h18,      8'h00, 8'h00, 1'b1},
      '{1'b1, OFF_BAUD_HI, 8'h0a, 8'h00, 1'b0},
      '{1'b0, OFF_BAUD_HI, 8'h00, 8'h0a, 1'b0},
      '{1'b1, OFF_BAUD_LO, 8'h05, 8'h00, 1'b0},
      '{1'b0, OFF_BAUD_LO, 8'h00, 8'h05, 1'b0},
      '{1'b1, OFF_BAUD_HI, 8'h00, 8'h00, 1'b0},
      '{1'b1, OFF_BAUD_LO, 8'h00, 8'h00, 1'b0},
      '{1'b1, OFF_STAT_A, 8'h02, 8'h00, 1'b0},
      '{1'b0, OFF_STAT_A, 8'h00, 8'h22, 1'b0},
      '{1'b1, OFF_STAT_A, 8'h00, 8'h00, 1'b0},
      '{1'b1, OFF_CTRL_B, 8'h18, 8'h00, 1'b0},
      '{1'b0, OFF_CTRL_B, 8'h00, 8'h18, 1'b0},
      '{1'b0, OFF_DATA,   8'h00, 8'h00, 1'b0}};

   usart_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .global_irq_enable(gie), .txc_irq_ack(ack), .rxc_irq_req(rxc_req),
      .txc_irq_req(txc_req), .udre_irq_req(udre_req), .rxd_pin(rxd), .rxd_owned(rxd_owned),
      .txd_out(txd), .txd_oe(txd_oe));
   serial_peer peer_u (.pclk(pclk), .txd(txd), .rxd(rxd), .got(got), .frames(frames));

   // ==================================================
   // Tasks
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] r, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00, rd, er);
      chk("read", {24'h0, e}, rd);
   endtask
   task automatic wait_frames(input logic [3:0] n);
      int k;
      k = 0;
      while (frames !== n && k < 1000) begin
         @(posedge pclk);
         k++;
      end
      chk("frames", {28'h0, n}, {28'h0, frames});
   endtask
   task automatic report_and_stop;
      if (mismatches == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ==================================================
   // Clock, watchdog and main sequence
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   initial begin
      repeat (10000) @(posedge pclk);
      mismatches++;
      report_and_stop;
   end
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0; gie = 1'b0; ack = 1'b0;
      repeat (3) @(posedge pclk);
      chk("txd_oe", 32'h0, {31'h0, txd_oe});
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (rows[i]) begin
         bus(rows[i].wr, rows[i].a, rows[i].d, rd, er);
         chk("pslverr", {31'h0, rows[i].err}, {31'h0, er});
         if (!rows[i].wr) chk("row", {24'h0, rows[i].e}, rd);
      end
      // Two characters out, a third write lost while the buffer is full
      bus(1'b1, OFF_DATA, 8'h5a, rd, er);
      repeat (2) @(posedge pclk);
      chk("txd", 32'h0, {31'h0, txd});
      chk("txd_oe", 32'h1, {31'h0, txd_oe});
      bus(1'b1, OFF_DATA, 8'h11, rd, er);
      bus(1'b1, OFF_DATA, 8'h22, rd, er);
      rdchk(OFF_STAT_A, 8'h00);
      wait_frames(4'h1);
      chk("frame", 32'h15a, {23'h0, got});
      wait_frames(4'h2);
      chk("frame", 32'h111, {23'h0, got});
      repeat (200) @(posedge pclk);
      chk("frames", 32'h2, {28'h0, frames});
      rdchk(OFF_STAT_A, 8'h60);
      gie <= 1'b1;
      bus(1'b1, OFF_CTRL_B, 8'h78, rd, er);
      chk("irq", 32'h3, {30'h0, txc_req, udre_req});
      chk("rxc_irq", 32'h0, {31'h0, rxc_req});
      ack <= 1'b1;
      @(posedge pclk);
      ack <= 1'b0;
      @(posedge pclk);
      chk("irq", 32'h1, {30'h0, txc_req, udre_req});
      gie <= 1'b0;
      @(posedge pclk);
      chk("irq", 32'h0, {30'h0, txc_req, udre_req});
      // Nine-bit character, then transmit complete cleared by a written one
      bus(1'b1, OFF_CTRL_B, 8'h7c, rd, er);
      bus(1'b1, OFF_DATA, 8'h8a, rd, er);
      wait_frames(4'h3);
      chk("frame", 32'h08a, {23'h0, got});
      repeat (40) @(posedge pclk);
      rdchk(OFF_STAT_A, 8'h60);
      bus(1'b1, OFF_STAT_A, 8'h40, rd, er);
      rdchk(OFF_STAT_A, 8'h20);
      bus(1'b1, OFF_CTRL_B, 8'h10, rd, er);
      repeat (2) @(posedge pclk);
      chk("txd_oe", 32'h0, {31'h0, txd_oe});
      chk("rxd_owned", 32'h1, {31'h0, rxd_owned});
      // Receive a good character, then a short one with a bad stop bit
      peer_u.send(8'ha5, 1'b1);
      peer_u.send(8'h3c, 1'b0);
      repeat (40) @(posedge pclk);
      rdchk(OFF_STAT_A, 8'ha0);
      rdchk(OFF_DATA, 8'ha5);
      rdchk(OFF_STAT_A, 8'hb0);
      rdchk(OFF_DATA, 8'h3c);
      rdchk(OFF_STAT_A, 8'h20);
      // Multi-processor mode drops a frame with no address mark
      bus(1'b1, OFF_STAT_A, 8'h01, rd, er);
      peer_u.send(8'h33, 1'b0);
      repeat (40) @(posedge pclk);
      rdchk(OFF_STAT_A, 8'h21);
      bus(1'b1, OFF_STAT_A, 8'h00, rd, er);
      bus(1'b1, OFF_CTRL_C, 8'h00, rd, er);
      peer_u.send(8'hff, 1'b1);
      repeat (40) @(posedge pclk);
      rdchk(OFF_DATA, 8'h1f);
      bus(1'b1, OFF_CTRL_C, 8'h06, rd, er);
      // Overrun, then flush by receiver disable
      for (int i = 0; i < 4; i++) peer_u.send(8'h40 + 8'(i), 1'b1);
      repeat (20) @(posedge pclk);
      rdchk(OFF_STAT_A, 8'ha8);
      rdchk(OFF_DATA, 8'h40);
      rdchk(OFF_DATA, 8'h41);
      rdchk(OFF_STAT_A, 8'ha0);
      bus(1'b1, OFF_CTRL_B, 8'h00, rd, er);
      repeat (2) @(posedge pclk);
      rdchk(OFF_STAT_A, 8'h20);
      chk("rxd_owned", 32'h0, {31'h0, rxd_owned});
      report_and_stop;
   end
endmodule
`default_nettype wire

// file: verilog/usart_pkg.sv
// Register map, field positions and reset values of the serial channel
package usart_pkg;
   // ==================================================
   // Register byte addresses
   localparam logic [7:0] OFF_DATA    = 8'h00;
   localparam logic [7:0] OFF_STAT_A  = 8'h04;
   localparam logic [7:0] OFF_CTRL_B  = 8'h08;
   localparam logic [7:0] OFF_CTRL_C  = 8'h0c;
   localparam logic [7:0] OFF_BAUD_LO = 8'h10;
   localparam logic [7:0] OFF_BAUD_HI = 8'h14;
   // ==================================================
   // Status and control A fields
   localparam int A_RXC  = 7;
   localparam int A_TXC  = 6;
   localparam int A_UDRE = 5;
   localparam int A_FE   = 4;
   localparam int A_DOR  = 3;
   localparam int A_PE   = 2;
   localparam int A_U2X  = 1;
   localparam int A_MPCM = 0;
   // ==================================================
   // Control B fields
   localparam int B_RXCIE = 7;
   localparam int B_TXCIE = 6;
   localparam int B_UDRIE = 5;
   localparam int B_RXEN  = 4;
   localparam int B_TXEN  = 3;
   localparam int B_CSZ2  = 2;
   localparam int B_RXB8  = 1;
   localparam int B_TXB8  = 0;
   // ==================================================
   // Control C fields
   localparam int C_UMSEL = 6;
   localparam int C_UPM1  = 5;
   localparam int C_UPM0  = 4;
   localparam int C_USBS  = 3;
   localparam int C_CSZ1  = 2;
   localparam int C_CSZ0  = 1;
   // ==================================================
   // Reset values
   localparam logic [7:0]  RST_STAT_A = 8'h20;
   localparam logic [7:0]  RST_CTRL_B = 8'h00;
   localparam logic [7:0]  RST_CTRL_C = 8'h06;
   localparam logic [11:0] RST_BAUD   = 12'h000;
   // ==================================================
   // Divider ticks per bit and receive FIFO depth
   localparam logic [4:0] TPB_NORMAL = 5'h10;
   localparam logic [4:0] TPB_DOUBLE = 5'h08;
   localparam logic [4:0] TPB_SYNC   = 5'h02;
   localparam logic [1:0] FIFO_DEPTH = 2'h2;
endpackage

// file: verilog/usart_regs.sv
// Serial channel with APB register file, transmitter and receiver
//
// Summary of operation
// - One data address: writes feed transmit buffer, reads return receive buffer.
// - Unused upper data bits ignored on transmit and read as zero on receive.
// - Data writes while buffer-empty flag is clear are discarded.
// - Enabled transmitter moves buffer into empty shift register and sends it.
// - Receive buffer is a two-entry FIFO advanced by every data read.
// - Receive-complete flag shows unread data; drops when receiver disable flushes.
// - Transmit-complete sets after frame out with buffer empty; cleared by ack or one.
// - Buffer-empty flag is one while buffer accepts data, and after reset.
// - Frame-error flag shows zero first stop bit of head character.
// - Overrun flag sets on start bit with FIFO full and a character held.
// - Parity-error flag shows parity failure of head character when checking enabled.
// - Double speed divides by 8 instead of 16 in asynchronous operation.
// - Multi-processor mode drops received frames carrying no address mark.
// - Each interrupt request needs its enable, global enable and status flag.
// - Receiver enable owns the receive pin; clearing it flushes data and errors.
// - Transmitter enable owns the transmit pin; disable waits for pending data.
// - Mode select zero is asynchronous, one is synchronous.
// - Parity mode: 00 off, 01 reserved, 10 even, 11 odd.
// - Stop select gives one or two transmitted stop bits; receiver ignores it.
// - Character size codes select five to nine data bits.
// - Twelve-bit divider; low-part write reloads the prescaler at once.
`timescale 1ns/1ps
`default_nettype none
module usart_regs
   import usart_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Interrupt handshake with the processor
   input  wire logic        global_irq_enable,
   input  wire logic        txc_irq_ack,
   output logic             rxc_irq_req,
   output logic             txc_irq_req,
   output logic             udre_irq_req,
   // Serial pins
   input  wire logic        rxd_pin,
   output logic             rxd_owned,
   output logic             txd_out,
   output logic             txd_oe
);
   // ==================================================
   // Register state
   typedef enum logic [2:0] {
      RX_IDLE  = 3'b001,
      RX_START = 3'b010,
      RX_SHIFT = 3'b100
   } rx_state_t;

   logic [7:0]  prdata_ff;
   logic        txc_ff, u2x_ff, mpcm_ff;
   logic        rxcie_ff, txcie_ff, udrie_ff, rxen_ff, txen_ff, csz2_ff, txb8_ff;
   logic        umsel_ff, usbs_ff;
   logic [1:0]  upm_ff, csz_lo_ff;
   logic [11:0] ubrr_ff, presc_ff;
   logic        dor_ff;
   // Transmit side
   logic [8:0]  tx_buf_ff;
   logic        tx_buf_v_ff, tx_busy_ff, tx_active_ff;
   logic [12:0] tx_frame_ff;
   logic [3:0]  tx_left_ff;
   logic [4:0]  tx_tick_ff;
   // Receive side
   rx_state_t   rx_state_ff;
   logic        rxd_meta_ff, rxd_sync_ff;
   logic [10:0] rx_shift_ff;
   logic [3:0]  rx_left_ff;
   logic [4:0]  rx_tick_ff;
   logic [10:0] fifo_ff [2];
   logic [1:0]  fifo_cnt_ff;
   logic [10:0] hold_ff;
   logic        hold_v_ff;

   // ==================================================
   // APB decode
   wire         acc      = psel & penable;
   wire         wr       = acc & pwrite;
   wire         rd       = acc & ~pwrite;
   wire         hit_data = paddr == OFF_DATA;
   wire         hit_a    = paddr == OFF_STAT_A;
   wire         hit_b    = paddr == OFF_CTRL_B;
   wire         hit_c    = paddr == OFF_CTRL_C;
   wire         hit_lo   = paddr == OFF_BAUD_LO;
   wire         hit_hi   = paddr == OFF_BAUD_HI;
   wire         mapped   = hit_data | hit_a | hit_b | hit_c | hit_lo | hit_hi;
   wire         wr_data  = wr & hit_data;
   wire         rd_data  = rd & hit_data;
   wire         wr_a     = wr & hit_a;
   wire         wr_lo    = wr & hit_lo;

   assign pready  = 1'b1;
   assign pslverr = acc & ~mapped;

   // ==================================================
   // Frame format
   function automatic logic [3:0] char_bits(input logic [2:0] code);
      unique case (code)
         3'b000:  char_bits = 4'd5;
         3'b001:  char_bits = 4'd6;
         3'b010:  char_bits = 4'd7;
         3'b111:  char_bits = 4'd9;
         default: char_bits = 4'd8; // Reserved codes act as eight bits
      endcase
   endfunction

   wire [3:0]  nbits    = char_bits({csz2_ff, csz_lo_ff});
   wire        par_en   = upm_ff[1];
   wire [8:0]  dmask    = 9'h1ff >> (4'd9 - nbits);
   wire [4:0]  tpb      = umsel_ff ? TPB_SYNC : (u2x_ff ? TPB_DOUBLE : TPB_NORMAL);
   wire [4:0]  half_tpb = {1'b0, tpb[4:1]};

   // ==================================================
   // Baud prescaler
   wire baud_tick = presc_ff == 12'h000;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_ff <= RST_BAUD;
      end else if (wr_lo) begin
         presc_ff <= {ubrr_ff[11:8], pwdata[7:0]};
      end else if (baud_tick) begin
         presc_ff <= ubrr_ff;
      end else begin
         presc_ff <= presc_ff - 12'h001;
      end
   end

   // ==================================================
   // Control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {u2x_ff, mpcm_ff} <= RST_STAT_A[1:0];
         {rxcie_ff, txcie_ff, udrie_ff, rxen_ff, txen_ff, csz2_ff, txb8_ff} <=
            {RST_CTRL_B[7:2], RST_CTRL_B[0]};
         {umsel_ff, upm_ff, usbs_ff, csz_lo_ff} <= RST_CTRL_C[6:1];
         ubrr_ff <= RST_BAUD;
      end else if (wr) begin
         if (hit_a) begin
            u2x_ff  <= pwdata[A_U2X];
            mpcm_ff <= pwdata[A_MPCM];
         end
         if (hit_b) begin
            {rxcie_ff, txcie_ff, udrie_ff} <= pwdata[7:5];
            {rxen_ff, txen_ff, csz2_ff} <= pwdata[4:2];
            txb8_ff <= pwdata[B_TXB8];
         end
         if (hit_c) begin
            {umsel_ff, upm_ff, usbs_ff, csz_lo_ff} <= pwdata[6:1];
         end
         if (hit_lo) begin
            ubrr_ff[7:0] <= pwdata[7:0];
         end
         if (hit_hi) begin
            ubrr_ff[11:8] <= pwdata[3:0];
         end
      end
   end

   // ==================================================
   // Transmit buffer and shifter
   wire       tx_load   = tx_active_ff & tx_buf_v_ff & ~tx_busy_ff;
   wire       tx_bitend = tx_busy_ff & baud_tick & (tx_tick_ff == tpb - 5'd1);
   wire       tx_done   = tx_bitend & (tx_left_ff == 4'd1);
   wire [8:0] tx_data   = tx_buf_ff & dmask;
   wire       tx_par    = ^tx_data ^ upm_ff[0];
   wire [9:0] tx_body   = {1'b0, tx_data} | ({9'h000, par_en & tx_par} << nbits);
   wire [3:0] tx_plen   = nbits + {3'b000, par_en};
   wire [12:0] tx_ones  = 13'h1fff << tx_plen;
   wire [12:0] tx_frame = {tx_ones[11:0] | {2'b00, tx_body}, 1'b0};
   wire [3:0] tx_total  = 4'd2 + tx_plen + {3'b000, usbs_ff};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_buf_ff   <= 9'h000;
         tx_buf_v_ff <= 1'b0;
      end else if (wr_data && !tx_buf_v_ff) begin
         tx_buf_ff   <= {txb8_ff, pwdata[7:0]};
         tx_buf_v_ff <= 1'b1;
      end else if (tx_load) begin
         tx_buf_v_ff <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_busy_ff  <= 1'b0;
         tx_frame_ff <= 13'h1fff;
         tx_left_ff  <= 4'h0;
         tx_tick_ff  <= 5'h00;
      end else if (tx_load) begin
         tx_busy_ff  <= 1'b1;
         tx_frame_ff <= tx_frame;
         tx_left_ff  <= tx_total;
         tx_tick_ff  <= 5'h00;
      end else if (tx_bitend) begin
         tx_busy_ff  <= ~tx_done;
         tx_frame_ff <= {1'b1, tx_frame_ff[12:1]};
         tx_left_ff  <= tx_left_ff - 4'd1;
         tx_tick_ff  <= 5'h00;
      end else if (tx_busy_ff && baud_tick) begin
         tx_tick_ff  <= tx_tick_ff + 5'd1;
      end
   end

   // Pin stays owned until pending data has gone
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_active_ff <= 1'b0;
      end else if (txen_ff) begin
         tx_active_ff <= 1'b1;
      end else if (!tx_busy_ff && !tx_buf_v_ff) begin
         tx_active_ff <= 1'b0;
      end
   end

   assign txd_oe  = tx_active_ff;
   assign txd_out = tx_busy_ff ? tx_frame_ff[0] : 1'b1;

   // Set wins over both clears
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txc_ff <= RST_STAT_A[A_TXC];
      end else if (tx_done && !tx_buf_v_ff) begin
         txc_ff <= 1'b1;
      end else if (txc_irq_ack || (wr_a && pwdata[A_TXC])) begin
         txc_ff <= 1'b0;
      end
   end

   // ==================================================
   // Receive line synchroniser and framer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxd_meta_ff <= 1'b1;
         rxd_sync_ff <= 1'b1;
      end else begin
         rxd_meta_ff <= rxd_pin;
         rxd_sync_ff <= rxd_meta_ff;
      end
   end

   wire        fifo_full = fifo_cnt_ff == FIFO_DEPTH;
   wire        rx_start  = rxen_ff & (rx_state_ff == RX_IDLE) & ~rxd_sync_ff;
   wire        rx_mid_s  = baud_tick & (rx_tick_ff == half_tpb - 5'd1);
   wire        rx_mid    = baud_tick & (rx_tick_ff == tpb - 5'd1);
   wire [3:0]  rx_total  = tx_plen + 4'd1; // Receiver checks one stop bit only
   wire        rx_done   = (rx_state_ff == RX_SHIFT) & rx_mid & (rx_left_ff == 4'd1);
   wire [10:0] rx_frame  = {rxd_sync_ff, rx_shift_ff[10:1]};
   wire [10:0] rx_align  = rx_frame >> (4'd11 - rx_total);
   wire [8:0]  rx_data   = rx_align[8:0] & dmask;
   wire        rx_pbit   = rx_align[nbits];
   wire        rx_stop   = rx_align[tx_plen];
   wire        rx_perr   = par_en & ((^rx_data ^ rx_pbit) != upm_ff[0]);
   wire        rx_ferr   = ~rx_stop;
   wire        rx_addr   = (nbits == 4'd9) ? rx_data[8] : rx_stop;
   wire        rx_keep   = rx_done & (~mpcm_ff | rx_addr);
   wire [10:0] rx_entry  = {rx_ferr, rx_perr, rx_data};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_state_ff <= RX_IDLE;
         rx_shift_ff <= 11'h000;
         rx_left_ff  <= 4'h0;
         rx_tick_ff  <= 5'h00;
      end else if (!rxen_ff) begin
         rx_state_ff <= RX_IDLE;
      end else begin
         unique case (rx_state_ff)
            RX_IDLE: begin
               rx_tick_ff <= 5'h00;
               if (rx_start) begin
                  rx_state_ff <= RX_START;
               end
            end
            RX_START: begin
               if (rx_mid_s) begin
                  rx_tick_ff  <= 5'h00;
                  rx_left_ff  <= rx_total;
                  rx_state_ff <= rxd_sync_ff ? RX_IDLE : RX_SHIFT;
               end else if (baud_tick) begin
                  rx_tick_ff <= rx_tick_ff + 5'd1;
               end
            end
            RX_SHIFT: begin
               if (rx_mid) begin
                  rx_tick_ff  <= 5'h00;
                  rx_shift_ff <= rx_frame;
                  rx_left_ff  <= rx_left_ff - 4'd1;
                  if (rx_left_ff == 4'd1) begin
                     rx_state_ff <= RX_IDLE;
                  end
               end else if (baud_tick) begin
                  rx_tick_ff <= rx_tick_ff + 5'd1;
               end
            end
            default: rx_state_ff <= RX_IDLE;
         endcase
      end
   end

   // ==================================================
   // Receive FIFO with one character held behind it
   wire        pop       = rd_data & (fifo_cnt_ff != 2'd0);
   wire        fifo_free = ~fifo_full | pop;
   wire        push_hold = hold_v_ff & fifo_free;
   wire        push_new  = rx_keep & ~hold_v_ff & fifo_free;
   wire        push      = push_hold | push_new;
   wire [10:0] push_val  = hold_v_ff ? hold_ff : rx_entry;
   wire [1:0]  cnt_pop   = fifo_cnt_ff - {1'b0, pop};
   wire        ovr_event = rx_start & fifo_full & hold_v_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo_cnt_ff <= 2'd0;
         fifo_ff[0]  <= 11'h000;
         fifo_ff[1]  <= 11'h000;
      end else if (!rxen_ff) begin
         fifo_cnt_ff <= 2'd0;
      end else begin
         if (pop) begin
            fifo_ff[0] <= fifo_ff[1];
         end
         if (push) begin
            fifo_ff[cnt_pop[0]] <= push_val;
         end
         fifo_cnt_ff <= cnt_pop + {1'b0, push};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_v_ff <= 1'b0;
         hold_ff   <= 11'h000;
      end else if (!rxen_ff) begin
         hold_v_ff <= 1'b0;
      end else if (push_hold) begin
         hold_v_ff <= rx_keep;
         hold_ff   <= rx_entry;
      end else if (rx_keep && !hold_v_ff && !fifo_free) begin
         hold_v_ff <= 1'b1;
         hold_ff   <= rx_entry;
      end
   end

   // Overrun set wins over the read that clears it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dor_ff <= 1'b0;
      end else if (!rxen_ff) begin
         dor_ff <= 1'b0;
      end else if (ovr_event) begin
         dor_ff <= 1'b1;
      end else if (rd_data) begin
         dor_ff <= 1'b0;
      end
   end

   assign rxd_owned = rxen_ff;

   // ==================================================
   // Status view and read data
   wire       rxc_flag  = fifo_cnt_ff != 2'd0;
   wire       udre_flag = ~tx_buf_v_ff;
   wire [10:0] head     = rxc_flag ? fifo_ff[0] : 11'h000;
   wire [7:0] stat_a    = {rxc_flag, txc_ff, udre_flag, head[10], dor_ff, head[9],
                           u2x_ff, mpcm_ff};
   wire [7:0] ctrl_b    = {rxcie_ff, txcie_ff, udrie_ff, rxen_ff, txen_ff, csz2_ff,
                           head[8], txb8_ff};
   wire [7:0] ctrl_c    = {1'b0, umsel_ff, upm_ff, usbs_ff, csz_lo_ff, 1'b0};
   wire [7:0] rd_mux    = hit_data ? head[7:0] :
                          hit_a    ? stat_a :
                          hit_b    ? ctrl_b :
                          hit_c    ? ctrl_c :
                          hit_lo   ? ubrr_ff[7:0] :
                          hit_hi   ? {4'h0, ubrr_ff[11:8]} : 8'h00;

   // Read data is captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 8'h00;
      end else if (psel && !penable && !pwrite) begin
         prdata_ff <= rd_mux;
      end
   end
   assign prdata = {24'h000000, prdata_ff};

   assign rxc_irq_req  = global_irq_enable & rxcie_ff & rxc_flag;
   assign txc_irq_req  = global_irq_enable & txcie_ff & txc_ff;
   assign udre_irq_req = global_irq_enable & udrie_ff & udre_flag;

   // ==================================================
   // Checks
   property p_write_ignored;
      @(posedge pclk) disable iff (!presetn)
      (wr_data && tx_buf_v_ff) |=> $stable(tx_buf_ff);
   endproperty
   a_write_ignored: assert property (p_write_ignored)
      else $error("data write accepted while buffer full");

   property p_load;
      @(posedge pclk) disable iff (!presetn)
      tx_load |=> tx_busy_ff && udre_flag && !txd_out;
   endproperty
   a_load: assert property (p_load)
      else $error("buffer not moved into shifter");

   property p_pop;
      @(posedge pclk) disable iff (!presetn)
      (rxen_ff && rd_data && fifo_cnt_ff == 2'd2 && !push) |=> fifo_cnt_ff == 2'd1;
   endproperty
   a_pop: assert property (p_pop)
      else $error("data read did not advance receive fifo");

   property p_flush;
      @(posedge pclk) disable iff (!presetn)
      !rxen_ff |=> !stat_a[A_RXC] && !stat_a[A_FE] && !stat_a[A_DOR] && !stat_a[A_PE];
   endproperty
   a_flush: assert property (p_flush)
      else $error("receiver disable left data or errors");

   property p_txc_set;
      @(posedge pclk) disable iff (!presetn)
      (tx_done && !tx_buf_v_ff) |=> txc_ff;
   endproperty
   a_txc_set: assert property (p_txc_set)
      else $error("transmit complete not set");

   property p_txc_clr;
      @(posedge pclk) disable iff (!presetn)
      (wr_a && pwdata[A_TXC] && !tx_done) |=> !txc_ff;
   endproperty
   a_txc_clr: assert property (p_txc_clr)
      else $error("transmit complete not cleared by write of one");

   property p_irq;
      @(posedge pclk) disable iff (!presetn)
      (rxc_irq_req || txc_irq_req || udre_irq_req) |-> global_irq_enable;
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt request without global enable");

   property p_release;
      @(posedge pclk) disable iff (!presetn)
      (!txen_ff && !tx_busy_ff && !tx_buf_v_ff) |=> !txd_oe;
   endproperty
   a_release: assert property (p_release)
      else $error("transmit pin kept after disable");

   property p_prescale;
      @(posedge pclk) disable iff (!presetn)
      wr_lo |=> presc_ff == {$past(ubrr_ff[11:8]), $past(pwdata[7:0])};
   endproperty
   a_prescale: assert property (p_prescale)
      else $error("prescaler not reloaded on low divider write");
endmodule
`default_nettype wire
